/* File: dcpwm_checker.sv */
`timescale 1ns/10ps
module dcpwm_checker (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // waves
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic wave_out_c,
  // interrupt requests
  input wire logic irq_a
);
  default clocking dcpwm_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [7:0] ctrl_q;
  wire acc = psel && penable;
  wire cas = ctrl_q[6:5] == 2'h3;
  // shadow of the control register, taken at each completed write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
    end else if (acc && pwrite && paddr == 12'h020) begin
      ctrl_q <= pwdata[7:0];
    end
  end
  // ----------
  // assertions
  // ----------
  zero_wait_a: assert property (acc |-> pready)
    else $error("access without ready");
  bad_addr_a: assert property (acc && (paddr > 12'h034 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped access not refused");
  idle_data_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  mode_ones_a: assert property (
    acc && !pwrite && paddr == 12'h024 |-> prdata[7:1] == 7'h7f)
    else $error("mode upper bits not one");
  lo_halt_a: assert property (!ctrl_q[0] && $past(!ctrl_q[0]) |-> wave_out_a && wave_out_c)
    else $error("halted low channel not high");
  hi_halt_a: assert property (
    !cas && $past(!cas) && !ctrl_q[4] && $past(!ctrl_q[4]) |-> wave_out_b)
    else $error("halted high channel not high");
  cas_quiet_a: assert property (cas && $past(cas) |-> wave_out_a && wave_out_c)
    else $error("unused output moved in cascade");
  lo_fall_a: assert property ($fell(wave_out_a) |-> $past(ctrl_q[0]) || $past(ctrl_q[0], 2))
    else $error("output fell while stopped");
  lo_irq_quiet_a: assert property (!ctrl_q[0] && $past(!ctrl_q[0]) && !cas |-> !irq_a)
    else $error("irq while low counter stopped");
  cover property (acc && pslverr);
  cover property ($fell(wave_out_b) && cas);
  cover property ($rose(wave_out_a));
endmodule

/* File: dcpwm_defs.svh */
`ifndef DCPWM_DEFS_SVH
`define DCPWM_DEFS_SVH

// ----------------------------------------
// register byte addresses (one word each)
// ----------------------------------------
`define DCPWM_ADDR_DUTY_A 12'h000
`define DCPWM_ADDR_DUTY_B 12'h004
`define DCPWM_ADDR_DUTY_C 12'h008
`define DCPWM_ADDR_DUTY_D 12'h00c
`define DCPWM_ADDR_LOW_CYCLE 12'h010
`define DCPWM_ADDR_HIGH_CYCLE 12'h014
`define DCPWM_ADDR_LOW_COUNTER 12'h018
`define DCPWM_ADDR_HIGH_COUNTER 12'h01c
`define DCPWM_ADDR_RUN_CLOCK_CONTROL 12'h020
`define DCPWM_ADDR_SPEED_MODE 12'h024
`define DCPWM_ADDR_DUTY_PAIR_AB 12'h028
`define DCPWM_ADDR_DUTY_PAIR_CD 12'h02c
`define DCPWM_ADDR_CASCADED_CYCLE 12'h030
`define DCPWM_ADDR_CASCADED_COUNTER 12'h034

// ----------------------------------------
// control and speed-mode field positions
// ----------------------------------------
`define DCPWM_LO_RUN_BIT 0
`define DCPWM_LO_CLK_LSB 1
`define DCPWM_LO_IRQ_BIT 3
`define DCPWM_HI_RUN_BIT 4
`define DCPWM_HI_CLK_LSB 5
`define DCPWM_HI_IRQ_BIT 7
`define DCPWM_HS_BIT 0

// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define DCPWM_SPEED_MODE_RESET 8'hfe
`define DCPWM_CTRL_RESET 8'h00
`define DCPWM_CASCADE_SEL 2'h3

`endif

/* File: dcpwm_pkg.sv */
package dcpwm_pkg;
  typedef logic [7:0] dcpwm_byte_type;
  typedef logic [1:0] dcpwm_clk_sel_type;
endpackage

/* File: dcpwm_top.sv */
`timescale 1ns/10ps
`include "dcpwm_defs.svh"
module dcpwm_top #(
  parameter logic [1:0] SEL_DIV1 = 2'h0,
  parameter logic [1:0] SEL_DIV2 = 2'h1,
  parameter logic [1:0] SEL_DIV4 = 2'h2,
  parameter logic IRQ_ON_OVERFLOW = 1'b1
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pwm outputs and interrupt requests
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_out_c,
  output logic wave_out_d,
  output logic irq_a,
  output logic irq_b,
  output logic irq_c,
  output logic irq_d
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  dcpwm_pkg::dcpwm_byte_type duty_q [4];
  dcpwm_pkg::dcpwm_byte_type cyc_q [2];
  dcpwm_pkg::dcpwm_byte_type cnt_q [2];
  dcpwm_pkg::dcpwm_byte_type ctrl_q;
  logic hs_q;
  logic [1:0] run_q;
  logic [1:0] prs_q;
  logic [3:0] out_q;
  logic [3:0] irq_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire [11:0] a = paddr;
  wire [7:0] wb0 = pwdata[7:0];
  wire [7:0] wb1 = pwdata[15:8];
  wire wr_duty_a = wr && a == `DCPWM_ADDR_DUTY_A;
  wire wr_duty_b = wr && a == `DCPWM_ADDR_DUTY_B;
  wire wr_duty_c = wr && a == `DCPWM_ADDR_DUTY_C;
  wire wr_duty_d = wr && a == `DCPWM_ADDR_DUTY_D;
  wire wr_pair_ab = wr && a == `DCPWM_ADDR_DUTY_PAIR_AB;
  wire wr_pair_cd = wr && a == `DCPWM_ADDR_DUTY_PAIR_CD;
  wire wr_cyc_lo = wr && a == `DCPWM_ADDR_LOW_CYCLE;
  wire wr_cyc_hi = wr && a == `DCPWM_ADDR_HIGH_CYCLE;
  wire wr_cyc_w = wr && a == `DCPWM_ADDR_CASCADED_CYCLE;
  wire wr_cnt_lo = wr && a == `DCPWM_ADDR_LOW_COUNTER;
  wire wr_cnt_hi = wr && a == `DCPWM_ADDR_HIGH_COUNTER;
  wire wr_cnt_w = wr && a == `DCPWM_ADDR_CASCADED_COUNTER;
  wire wr_ctrl = wr && a == `DCPWM_ADDR_RUN_CLOCK_CONTROL;
  wire wr_mode = wr && a == `DCPWM_ADDR_SPEED_MODE;

  // ----------------------------------------
  // mode and clock selection
  // ----------------------------------------
  // count clock sel
  wire [1:0] lo_sel = ctrl_q[`DCPWM_LO_CLK_LSB+:2];
  wire [1:0] hi_sel = ctrl_q[`DCPWM_HI_CLK_LSB+:2];
  wire casc = hi_sel == `DCPWM_CASCADE_SEL;
  wire hs = casc && hs_q;
  wire lo_run_bit = ctrl_q[`DCPWM_LO_RUN_BIT];
  wire hi_run_bit = ctrl_q[`DCPWM_HI_RUN_BIT];
  wire run0 = hs ? hi_run_bit : lo_run_bit && (!casc || hi_run_bit);
  wire run1 = casc ? run0 : hi_run_bit;

  // prescaler ticks; unknown codes count at the slowest rate
  function automatic logic tick_of(input logic [1:0] s, input logic [1:0] p);
    tick_of = s == SEL_DIV1 ? 1'b1 : s == SEL_DIV2 ? p[0] : (p == 2'h3);
  endfunction
  wire tick0 = run0 && tick_of(lo_sel, prs_q);
  wire tick1n = run1 && !casc && tick_of(hi_sel, prs_q);

  // ----------------------------------------
  // counting
  // ----------------------------------------
  // up-count with reload; high-speed carries upper into lower
  wire [15:0] cnt16 = {cnt_q[1], cnt_q[0]};
  wire [15:0] cyc16 = {cyc_q[1], cyc_q[0]};
  wire ov0 = tick0 && !hs && cnt_q[0] == 8'hff;
  wire ov1 = casc ? (tick0 && cnt16 == 16'hffff) : (tick1n && cnt_q[1] == 8'hff);
  // high-speed order: upper byte is the fast digit
  wire [15:0] hs_cnt = {cnt_q[0], cnt_q[1]};
  wire [15:0] hs_cyc = {cyc_q[0], cyc_q[1]};
  wire [15:0] hs_nxt = (hs_cnt == 16'hffff) ? hs_cyc : hs_cnt + 16'h0001;
  wire [15:0] c_nxt = (cnt16 == 16'hffff) ? cyc16 : cnt16 + 16'h0001;
  logic [7:0] cnt0_d;
  logic [7:0] cnt1_d;
  always_comb begin
    cnt0_d = cnt_q[0];
    cnt1_d = cnt_q[1];
    if (hs && tick0) begin
      cnt0_d = hs_nxt[15:8];
      cnt1_d = hs_nxt[7:0];
    end else if (casc && tick0) begin
      cnt0_d = c_nxt[7:0];
      cnt1_d = c_nxt[15:8];
    end else begin
      if (tick0) begin
        cnt0_d = (cnt_q[0] == 8'hff) ? cyc_q[0] : cnt_q[0] + 8'h01;
      end
      if (tick1n) begin
        cnt1_d = (cnt_q[1] == 8'hff) ? cyc_q[1] : cnt_q[1] + 8'h01;
      end
    end
    if (wr_cnt_lo || wr_cnt_w) begin
      cnt0_d = wb0;
    end
    if (wr_cnt_hi) begin
      cnt1_d = wb0;
    end
    if (wr_cnt_w) begin
      cnt1_d = wb1;
    end
  end

  // ----------------------------------------
  // compare and output flip-flops
  // ----------------------------------------
  wire [15:0] pair_ab = {duty_q[1], duty_q[0]};
  wire [15:0] pair_cd = {duty_q[3], duty_q[2]};
  wire m0 = tick0 && cnt_q[0] == duty_q[0];
  wire m2 = tick0 && cnt_q[0] == duty_q[2];
  wire m1 = casc ? tick0 && cnt16 == pair_ab : tick1n && cnt_q[1] == duty_q[1];
  wire m3 = casc ? tick0 && cnt16 == pair_cd : tick1n && cnt_q[1] == duty_q[3];
  wire [3:0] match = {m3, m2, m1, m0};
  wire [3:0] ovf = {ov1, ov0, ov1, ov0};
  wire [3:0] chrun = {run1, run0, run1, run0};
  wire [3:0] rise = {run1, run0, run1, run0} & ~{run_q[1], run_q[0], run_q[1], run_q[0]};
  logic [3:0] out_d;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      always_comb begin
        if (!chrun[gi] || rise[gi]) begin
          out_d[gi] = 1'b1;
        end else if (hs && (gi % 2 == 1)) begin
          out_d[gi] = hs_cnt <= ((gi == 1) ? pair_ab : pair_cd);
        // cascade drives only b and d
        end else if (casc && (gi % 2 == 0)) begin
          out_d[gi] = 1'b1;
        end else if (ovf[gi]) begin
          out_d[gi] = 1'b1;
        end else if (match[gi]) begin
          out_d[gi] = 1'b0;
        end else begin
          out_d[gi] = out_q[gi];
        end
      end
    end
  endgenerate

  wire src0 = ctrl_q[`DCPWM_LO_IRQ_BIT] == IRQ_ON_OVERFLOW;
  wire src1 = ctrl_q[`DCPWM_HI_IRQ_BIT] == IRQ_ON_OVERFLOW;
  wire [3:0] irq_nx = {m3, m2, src1 ? ov1 : m1, src0 ? ov0 : m0};
  localparam logic [7:0] MODE_RST = `DCPWM_SPEED_MODE_RESET;

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_q <= '{default: 8'h00};
      cyc_q <= '{default: 8'h00};
      cnt_q <= '{default: 8'h00};
      ctrl_q <= `DCPWM_CTRL_RESET;
      hs_q <= MODE_RST[`DCPWM_HS_BIT];
      run_q <= 2'h0;
      prs_q <= 2'h0;
      out_q <= 4'hf;
      irq_q <= 4'h0;
    end else begin
      if (wr_duty_a || wr_pair_ab) duty_q[0] <= wb0;
      if (wr_duty_b) duty_q[1] <= wb0;
      if (wr_pair_ab) duty_q[1] <= wb1;
      if (wr_duty_c || wr_pair_cd) duty_q[2] <= wb0;
      if (wr_duty_d) duty_q[3] <= wb0;
      if (wr_pair_cd) duty_q[3] <= wb1;
      if (wr_cyc_lo || wr_cyc_w || wr_cnt_lo || wr_cnt_w) cyc_q[0] <= wb0;
      if (wr_cyc_hi || wr_cnt_hi) cyc_q[1] <= wb0;
      if (wr_cyc_w || wr_cnt_w) cyc_q[1] <= wb1;
      cnt_q[0] <= cnt0_d;
      cnt_q[1] <= cnt1_d;
      if (wr_ctrl) ctrl_q <= wb0;
      if (wr_mode) hs_q <= wb0[`DCPWM_HS_BIT];
      run_q <= {run1, run0};
      prs_q <= prs_q + 2'h1;
      out_q <= out_d;
      irq_q <= irq_nx;
    end
  end

  // ----------------------------------------
  // read mux and outputs
  // ----------------------------------------
  logic [31:0] rd;
  always_comb begin
    unique case (a)
      `DCPWM_ADDR_DUTY_A: rd = {24'h00_0000, duty_q[0]};
      `DCPWM_ADDR_DUTY_B: rd = {24'h00_0000, duty_q[1]};
      `DCPWM_ADDR_DUTY_C: rd = {24'h00_0000, duty_q[2]};
      `DCPWM_ADDR_DUTY_D: rd = {24'h00_0000, duty_q[3]};
      `DCPWM_ADDR_DUTY_PAIR_AB: rd = {16'h0000, pair_ab};
      `DCPWM_ADDR_DUTY_PAIR_CD: rd = {16'h0000, pair_cd};
      `DCPWM_ADDR_LOW_CYCLE: rd = {24'h00_0000, cyc_q[0]};
      `DCPWM_ADDR_HIGH_CYCLE: rd = {24'h00_0000, cyc_q[1]};
      `DCPWM_ADDR_CASCADED_CYCLE: rd = {16'h0000, cyc16};
      `DCPWM_ADDR_LOW_COUNTER: rd = {24'h00_0000, cnt_q[0]};
      `DCPWM_ADDR_HIGH_COUNTER: rd = {24'h00_0000, cnt_q[1]};
      `DCPWM_ADDR_CASCADED_COUNTER: rd = {16'h0000, cnt16};
      `DCPWM_ADDR_RUN_CLOCK_CONTROL: rd = {24'h00_0000, ctrl_q};
      `DCPWM_ADDR_SPEED_MODE: rd = {24'h00_0000, 7'h7f, hs_q};
      default: rd = 32'h0000_0000;
    endcase
  end
  wire mapped = a[11:6] == 6'h00 && a[1:0] == 2'h0 && a[5:2] <= 4'hd;
  assign prdata = (acc && !pwrite) ? rd : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign wave_out_a = out_q[0];
  assign wave_out_b = out_q[1];
  assign wave_out_c = out_q[2];
  assign wave_out_d = out_q[3];
  assign irq_a = irq_q[0];
  assign irq_b = irq_q[1];
  assign irq_c = irq_q[2];
  assign irq_d = irq_q[3];
endmodule

/* File: dual_cascadable_pwm_control_tb_top.sv */
`timescale 1ns/10ps
`include "dcpwm_defs.svh"
module dual_cascadable_pwm_control_tb_top;
  localparam logic [11:0] CTL = `DCPWM_ADDR_RUN_CLOCK_CONTROL;
  localparam logic [11:0] MOD = `DCPWM_ADDR_SPEED_MODE;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] lfsr_q = 32'h0000_b8d9;
  logic [31:0] rd;
  logic [15:0] v;
  logic [11:0] a;
  logic [7:0] c0, c1, dv;
  logic err;
  int num_errors = 0;
  int tests_run = 0;
  int n;
  wire [31:0] prdata;
  wire pready, pslverr, wave_out_a, wave_out_b, wave_out_c, wave_out_d;
  wire [3:0] wv = {wave_out_d, wave_out_c, wave_out_b, wave_out_a};
  always #2.5 pclk = ~pclk;
  dcpwm_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wave_out_a, .wave_out_b, .wave_out_c, .wave_out_d,
    .irq_a(), .irq_b(), .irq_c(), .irq_d());
  // -------
  // helpers
  // -------
  function automatic int exp8(input int f, input logic [7:0] cy);
    return f * (256 - int'(cy));
  endfunction
  task automatic rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(negedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      @(negedge pclk);
    end
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // cycles between two rising edges, after lining up on one
  task automatic per(input int i, input int e);
    int c;
    while (wv[i] !== 1'b0) @(posedge pclk);
    while (wv[i] !== 1'b1) @(posedge pclk);
    for (c = 0; wv[i] !== 1'b0; c++) @(posedge pclk);
    for (c = c; wv[i] !== 1'b1; c++) @(posedge pclk);
    chk(c, e);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d compares", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
  // --------
  // sequence
  // --------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (a = 12'h000; a < 12'h038; a += 12'h004) begin
      apb(1'b0, a, 32'h0);
      chk(rd, (a == MOD) ? 32'h0000_00fe : 32'h0);
    end
    for (int k = 0; k < 3; k++) begin
      rnd();
      v = (k == 0) ? 16'h0000 : (k == 1) ? 16'h00ff : lfsr_q[15:0];
      apb(1'b1, MOD, {16'h0, v});
      apb(1'b0, MOD, 32'h0);
      chk(rd, {24'h0, 7'h7f, v[0]});
    end
    apb(1'b1, 12'h038, 32'hffff_ffff);
    chk(err, 1'b1);
    apb(1'b0, 12'h038, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    rnd();
    c0 = {1'b0, lfsr_q[6:0]};
    c1 = {1'b0, lfsr_q[14:8]};
    apb(1'b1, `DCPWM_ADDR_LOW_COUNTER, {24'h0, c0});
    apb(1'b1, `DCPWM_ADDR_HIGH_COUNTER, {24'h0, c1});
    apb(1'b0, `DCPWM_ADDR_LOW_CYCLE, 32'h0);
    chk(rd, {24'h0, c0});
    apb(1'b0, `DCPWM_ADDR_HIGH_CYCLE, 32'h0);
    chk(rd, {24'h0, c1});
    for (int k = 0; k < 4; k++) begin
      dv = (k[0] ? c1 : c0) + (k[1] ? 8'h40 : 8'h20);
      apb(1'b1, 12'(4 * k), {24'h0, dv});
      apb(1'b0, 12'(4 * k), 32'h0);
      chk(rd, {24'h0, dv});
    end
    // high-speed bit left set: no effect while not cascaded
    apb(1'b1, MOD, 32'h1);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, CTL, {24'h0, 1'b0, 2'(s), 2'b10, 2'(s), 1'b1});
      per(0, exp8(1 << s, c0));
      per(2, exp8(1 << s, c0));
      per(1, exp8(1 << s, c1));
    end
    apb(1'b1, CTL, 32'h0);
    repeat (4) @(posedge pclk);
    chk(wv, 4'hf);
    apb(1'b1, MOD, 32'h0);
    v = {9'h1fe, lfsr_q[22:16]};
    apb(1'b1, `DCPWM_ADDR_CASCADED_COUNTER, {16'h0, v});
    apb(1'b0, `DCPWM_ADDR_CASCADED_CYCLE, 32'h0);
    chk(rd, {16'h0, v});
    apb(1'b1, `DCPWM_ADDR_DUTY_PAIR_AB, {16'h0, v + 16'h0010});
    apb(1'b1, `DCPWM_ADDR_DUTY_PAIR_CD, {16'h0, v + 16'h0030});
    apb(1'b1, CTL, 32'h71);
    per(1, 65536 - int'(v));
    per(3, 65536 - int'(v));
    chk({wv[2], wv[0]}, 2'b11);
    apb(1'b1, CTL, 32'h70);
    repeat (4) @(posedge pclk);
    chk(wv, 4'hf);
    apb(1'b1, `DCPWM_ADDR_CASCADED_COUNTER, 32'h0);
    apb(1'b1, `DCPWM_ADDR_DUTY_PAIR_AB, 32'h0);
    apb(1'b1, MOD, 32'h1);
    apb(1'b1, CTL, 32'h70);
    for (n = 0; wv[1] !== 1'b0 && n < 600; n++) @(posedge pclk);
    chk(wv[1], 1'b0);
    apb(1'b1, CTL, 32'h61);
    repeat (4) @(posedge pclk);
    chk(wv[1], 1'b1);
    tally_and_finish();
  end
endmodule
bind dcpwm_top dcpwm_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .wave_out_a, .wave_out_b, .wave_out_c, .irq_a);
